// *** pkg/irfb_pkg.sv ***
// Constants and types shared by the integer register file and its bypass.
// Assumes a single core clock and a synchronous active-high reset.
package irfb_pkg;
	// ****************************************************************
	// Widths and counts
	// ****************************************************************
	localparam int XLEN      = 64;
	localparam int REG_COUNT = 32;
	localparam int ADDR_W    = 5;

	// ****************************************************************
	// Values after reset and fixed values
	// ****************************************************************
	localparam logic [ADDR_W-1:0] ZERO_REG    = 5'h00;
	localparam logic [XLEN-1:0]   REG_RESET   = 64'h0000_0000_0000_0000;
	localparam logic [XLEN-1:0]   MD_RESET    = 64'h0000_0000_0000_0000;
	localparam logic [XLEN-1:0]   PC_RESET    = 64'h0000_0000_0000_0000;
	localparam logic [XLEN-1:0]   PC_STEP     = 64'h0000_0000_0000_0004;

	// ****************************************************************
	// Source of the writeback value
	// ****************************************************************
	typedef enum logic [1:0] {
		WB_RESULT,
		WB_MOVE_HIGH,
		WB_MOVE_LOW,
		WB_MUL_DIRECT
	} irfb_wb_src_t;
endpackage

// *** pkg/irfb_fwd_if.sv ***
// Interface carrying the in-flight pipeline results to the bypass muxes.
// Assumes the register file top drives it and each read port reads it.
`timescale 1ns/1ps
interface irfb_fwd_if;
	logic                                 exValid;
	logic [irfb_pkg::ADDR_W-1:0]          exAddr;
	logic [irfb_pkg::XLEN-1:0]            exData;
	logic                                 memValid;
	logic [irfb_pkg::ADDR_W-1:0]          memAddr;
	logic [irfb_pkg::XLEN-1:0]            memData;
	logic                                 wbValid;
	logic [irfb_pkg::ADDR_W-1:0]          wbAddr;
	logic [irfb_pkg::XLEN-1:0]            wbData;

	modport src  (output exValid, exAddr, exData, memValid, memAddr,
		memData, wbValid, wbAddr, wbData);
	modport sink (input exValid, exAddr, exData, memValid, memAddr,
		memData, wbValid, wbAddr, wbData);
endinterface

// *** verilog/irfb_fwd_mux.sv ***
// Bypass mux for one read port: youngest in-flight result wins.
// Assumes the caller supplies the array word for the same address.
`timescale 1ns/1ps
module irfb_fwd_mux (
	input  wire logic                        clk,
	input  wire logic                        reset,
	irfb_fwd_if.sink                         fwd,
	input  wire logic [irfb_pkg::ADDR_W-1:0] rdAddr,
	input  wire logic [irfb_pkg::XLEN-1:0]   arrayData,
	output logic      [irfb_pkg::XLEN-1:0]   operand
);
	logic exHit;
	logic memHit;
	logic wbHit;

	// ****************************************************************
	// Hit detection on valid and address match; zero-register reads are overridden below
	// ****************************************************************
	assign exHit  = fwd.exValid && fwd.exAddr == rdAddr;
	assign memHit = fwd.memValid && fwd.memAddr == rdAddr;
	assign wbHit  = fwd.wbValid && fwd.wbAddr == rdAddr;

	// Priority: execute, then memory, then writeback, then array
	always_comb begin
		if (rdAddr == irfb_pkg::ZERO_REG) begin
			operand = irfb_pkg::REG_RESET;
		end else if (exHit) begin
			operand = fwd.exData;
		end else if (memHit) begin
			operand = fwd.memData;
		end else if (wbHit) begin
			operand = fwd.wbData;
		end else begin
			operand = arrayData;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	fwd_zero_a: assert property (@(posedge clk) disable iff (reset)
		rdAddr == irfb_pkg::ZERO_REG |-> operand == irfb_pkg::REG_RESET)
		else $error("zero register read not zero");
	fwd_ex_a: assert property (@(posedge clk) disable iff (reset)
		fwd.exValid && fwd.exAddr == rdAddr && rdAddr != irfb_pkg::ZERO_REG
		|-> operand == fwd.exData)
		else $error("execute result not forwarded");
	fwd_mem_a: assert property (@(posedge clk) disable iff (reset)
		fwd.memValid && fwd.memAddr == rdAddr
		&& rdAddr != irfb_pkg::ZERO_REG && !exHit
		|-> operand == fwd.memData)
		else $error("memory result not forwarded");
	fwd_array_a: assert property (@(posedge clk) disable iff (reset)
		!exHit && !memHit && !wbHit && rdAddr != irfb_pkg::ZERO_REG
		|-> operand == arrayData)
		else $error("array word not passed through");
endmodule // irfb_fwd_mux

// *** verilog/irfb_regfile.sv ***
// Integer register file with full bypass, result pair and program counter.
// Assumes decode reads, execute/memory/writeback stages report results.
// Notes on behaviour
// - Thirty-two general registers, each 64 bits wide.
// - Two independent read ports and one write port every cycle.
// - Every in-flight result is forwarded to a dependent read.
// - General registers feed arithmetic and effective-address generation.
// - Separate 64-bit high and low multiply/divide result registers.
// - A 64-bit program counter is kept beside the registers.
// - Memory only by load/store; ALU results read and write in one cycle.
// - Five-stage pipeline; reads and writebacks happen at fixed stages.
// - Multiply/divide fills high/low; move-from copies one to a register.
// - Three-operand multiply writes its product directly, low untouched.
`timescale 1ns/1ps
module irfb_regfile #(
	parameter int XLEN      = irfb_pkg::XLEN,
	parameter int REG_COUNT = irfb_pkg::REG_COUNT
) (
	input  wire logic                        clk,
	input  wire logic                        reset,
	input  wire logic [irfb_pkg::ADDR_W-1:0] rdAddrA,
	input  wire logic [irfb_pkg::ADDR_W-1:0] rdAddrB,
	input  wire logic [XLEN-1:0]             agenOffset,
	output logic      [XLEN-1:0]             rdDataA,
	output logic      [XLEN-1:0]             rdDataB,
	output logic      [XLEN-1:0]             effAddr,
	input  wire logic                        exValid,
	input  wire logic [irfb_pkg::ADDR_W-1:0] exAddr,
	input  wire logic [XLEN-1:0]             exData,
	input  wire logic                        memValid,
	input  wire logic [irfb_pkg::ADDR_W-1:0] memAddr,
	input  wire logic [XLEN-1:0]             memData,
	input  wire logic                        wbEn,
	input  wire irfb_pkg::irfb_wb_src_t      wbSrc,
	input  wire logic [irfb_pkg::ADDR_W-1:0] wbAddr,
	input  wire logic [XLEN-1:0]             wbData,
	input  wire logic                        mdWrEn,
	input  wire logic [XLEN-1:0]             mdHighIn,
	input  wire logic [XLEN-1:0]             mdLowIn,
	output logic      [XLEN-1:0]             muldivResultHigh,
	output logic      [XLEN-1:0]             muldivResultLow,
	input  wire logic                        pcLoad,
	input  wire logic [XLEN-1:0]             pcLoadValue,
	input  wire logic                        pcAdvance,
	output logic      [XLEN-1:0]             pc
);
	logic [XLEN-1:0] regArray [REG_COUNT];
	logic [XLEN-1:0] arrayA;
	logic [XLEN-1:0] arrayB;
	logic [XLEN-1:0] operandA;
	logic [XLEN-1:0] operandB;
	logic [XLEN-1:0] wrData;
	logic            wrEn;
	logic [XLEN-1:0] rdDataA_reg;
	logic [XLEN-1:0] rdDataB_reg;
	logic [XLEN-1:0] effAddr_reg;
	logic [XLEN-1:0] high_reg;
	logic [XLEN-1:0] low_reg;
	logic [XLEN-1:0] pc_reg;
	logic [XLEN-1:0] pc_next;

	irfb_fwd_if fwdBus ();

	// ****************************************************************
	// Writeback value selection
	// ****************************************************************
	// Move-from takes the result pair; a same-cycle update is seen
	always_comb begin
		case (wbSrc)
			irfb_pkg::WB_MOVE_HIGH: begin
				wrData = mdWrEn ? mdHighIn : high_reg;
			end
			irfb_pkg::WB_MOVE_LOW: begin
				wrData = mdWrEn ? mdLowIn : low_reg;
			end
			irfb_pkg::WB_MUL_DIRECT: begin
				wrData = wbData;
			end
			default: begin
				wrData = wbData;
			end
		endcase
	end
	assign wrEn = wbEn && wbAddr != irfb_pkg::ZERO_REG;

	// ****************************************************************
	// Forwarding sources; zero-register targets never bypass
	// ****************************************************************
	assign fwdBus.exValid  = exValid && exAddr != irfb_pkg::ZERO_REG;
	assign fwdBus.exAddr   = exAddr;
	assign fwdBus.exData   = exData;
	assign fwdBus.memValid = memValid && memAddr != irfb_pkg::ZERO_REG;
	assign fwdBus.memAddr  = memAddr;
	assign fwdBus.memData  = memData;
	assign fwdBus.wbValid  = wrEn;
	assign fwdBus.wbAddr   = wbAddr;
	assign fwdBus.wbData   = wrData;

	// ****************************************************************
	// Register array: one write port, two read ports
	// ****************************************************************
	// Writeback stage writes the array
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regArray[i] <= irfb_pkg::REG_RESET;
			end
		end else if (wrEn) begin
			regArray[wbAddr] <= wrData;
		end
	end
	assign arrayA = regArray[rdAddrA];
	assign arrayB = regArray[rdAddrB];

	// Bypass muxes, one per read port
	irfb_fwd_mux muxA (
		.clk       (clk),
		.reset     (reset),
		.fwd       (fwdBus),
		.rdAddr    (rdAddrA),
		.arrayData (arrayA),
		.operand   (operandA)
	);
	irfb_fwd_mux muxB (
		.clk       (clk),
		.reset     (reset),
		.fwd       (fwdBus),
		.rdAddr    (rdAddrB),
		.arrayData (arrayB),
		.operand   (operandB)
	);

	// Decode-stage read registers handed to execute
	always_ff @(posedge clk) begin
		if (reset) begin
			rdDataA_reg <= irfb_pkg::REG_RESET;
			rdDataB_reg <= irfb_pkg::REG_RESET;
		end else begin
			rdDataA_reg <= operandA;
			rdDataB_reg <= operandB;
		end
	end

	// Effective address from the first operand plus offset
	always_ff @(posedge clk) begin
		if (reset) begin
			effAddr_reg <= irfb_pkg::REG_RESET;
		end else begin
			effAddr_reg <= operandA + agenOffset;
		end
	end
	assign rdDataA = rdDataA_reg;
	assign rdDataB = rdDataB_reg;
	assign effAddr = effAddr_reg;

	// ****************************************************************
	// Multiply/divide result pair
	// ****************************************************************
	// Only the multiply/divide unit updates the pair
	always_ff @(posedge clk) begin
		if (reset) begin
			high_reg <= irfb_pkg::MD_RESET;
			low_reg  <= irfb_pkg::MD_RESET;
		end else if (mdWrEn) begin
			high_reg <= mdHighIn;
			low_reg  <= mdLowIn;
		end
	end
	assign muldivResultHigh = high_reg;
	assign muldivResultLow  = low_reg;

	// ****************************************************************
	// Program counter
	// ****************************************************************
	// Load beats advance
	always_comb begin
		if (pcLoad) begin
			pc_next = pcLoadValue;
		end else if (pcAdvance) begin
			pc_next = pc_reg + irfb_pkg::PC_STEP;
		end else begin
			pc_next = pc_reg;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			pc_reg <= irfb_pkg::PC_RESET;
		end else begin
			pc_reg <= pc_next;
		end
	end
	assign pc = pc_reg;

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence wb_then_read_s;
		wbEn && wbAddr != irfb_pkg::ZERO_REG ##1
		rdAddrA == $past(wbAddr) && !exValid && !memValid && !wbEn;
	endsequence
	wb_store_a: assert property (@(posedge clk) disable iff (reset)
		wb_then_read_s |=> rdDataA == $past(wrData, 2))
		else $error("written value not read back");
	zero_read_a: assert property (@(posedge clk) disable iff (reset)
		rdAddrB == irfb_pkg::ZERO_REG |=> rdDataB == irfb_pkg::REG_RESET)
		else $error("register zero read nonzero");
	ex_bypass_a: assert property (@(posedge clk) disable iff (reset)
		exValid && exAddr == rdAddrB && rdAddrB != irfb_pkg::ZERO_REG
		|=> rdDataB == $past(exData))
		else $error("execute result missed on port B");
	agen_sum_a: assert property (@(posedge clk) disable iff (reset)
		1'b1 |=> effAddr == $past(operandA) + $past(agenOffset))
		else $error("effective address wrong");
	pair_load_a: assert property (@(posedge clk) disable iff (reset)
		mdWrEn |=> muldivResultHigh == $past(mdHighIn)
		&& muldivResultLow == $past(mdLowIn))
		else $error("result pair not loaded");
	pair_hold_a: assert property (@(posedge clk) disable iff (reset)
		!mdWrEn |=> $stable(muldivResultLow) && $stable(muldivResultHigh))
		else $error("result pair changed without unit write");
	move_high_a: assert property (@(posedge clk) disable iff (reset)
		wbSrc == irfb_pkg::WB_MOVE_HIGH && !mdWrEn
		|-> wrData == muldivResultHigh)
		else $error("move from high took wrong value");
	pc_step_a: assert property (@(posedge clk) disable iff (reset)
		pcAdvance && !pcLoad |=> pc == $past(pc) + irfb_pkg::PC_STEP)
		else $error("program counter did not step");
	pc_load_a: assert property (@(posedge clk) disable iff (reset)
		pcLoad |=> pc == $past(pcLoadValue))
		else $error("program counter did not load");
endmodule // irfb_regfile

// *** test/irfb_stage_model.sv ***
// Far-side pipeline stages: in-flight results, writeback, multiply unit.
// Assumes the bench sets the held values by reference on the clock edge.
`timescale 1ns/1ps
module irfb_stage_model (
	input  wire logic       clk,
	output logic            exValid,
	output logic [4:0]      exAddr,
	output logic [63:0]     exData,
	output logic            memValid,
	output logic [4:0]      memAddr,
	output logic [63:0]     memData,
	output logic            wbEn,
	output irfb_pkg::irfb_wb_src_t wbSrc,
	output logic [4:0]      wbAddr,
	output logic [63:0]     wbData,
	output logic            mdWrEn,
	output logic [63:0]     mdHighIn,
	output logic [63:0]     mdLowIn
);
	logic [63:0] exD, memD, wbD, highD, lowD, pattReg;

	// Idle data lines flip every cycle so stale values never match
	always @(posedge clk) begin
		pattReg <= ~pattReg;
	end

	// Data is only meaningful while its stage claims it
	assign exData   = exValid ? exD : pattReg;
	assign memData  = memValid ? memD : pattReg;
	assign wbData   = wbEn ? wbD : pattReg;
	assign mdHighIn = mdWrEn ? highD : pattReg;
	assign mdLowIn  = mdWrEn ? lowD : ~pattReg;

	// Quiet pipeline at time zero
	initial begin
		{exValid, memValid, wbEn, mdWrEn} = 4'h0;
		{exAddr, memAddr, wbAddr} = 15'h0000;
		wbSrc = irfb_pkg::WB_RESULT;
		{exD, memD, wbD, highD, lowD} = '0;
		pattReg = 64'h5A5A_5A5A_5A5A_5A5A;
	end
endmodule // irfb_stage_model

// *** test/integer_register_file_bypass_tb_top.sv ***
// Self-checking bench for the register file with bypass.
// Assumes the stage model drives the pipeline side of the block.
`timescale 1ns/1ps
module integer_register_file_bypass_tb_top;
	logic        clk, reset, pcLoad, pcAdvance, exValid, memValid;
	logic        wbEn, mdWrEn;
	logic [4:0]  rdAddrA, rdAddrB, exAddr, memAddr, wbAddr;
	logic [63:0] agenOffset, pcLoadValue, rdDataA, rdDataB, effAddr, pc;
	logic [63:0] exData, memData, wbData, mdHighIn, mdLowIn;
	logic [63:0] muldivResultHigh, muldivResultLow;
	irfb_pkg::irfb_wb_src_t wbSrc;
	int          n_errors, comparisons, cyc;

	irfb_regfile DUT (.clk(clk), .reset(reset), .rdAddrA(rdAddrA),
		.rdAddrB(rdAddrB), .agenOffset(agenOffset), .rdDataA(rdDataA),
		.rdDataB(rdDataB), .effAddr(effAddr), .exValid(exValid),
		.exAddr(exAddr), .exData(exData), .memValid(memValid),
		.memAddr(memAddr), .memData(memData), .wbEn(wbEn), .wbSrc(wbSrc),
		.wbAddr(wbAddr), .wbData(wbData), .mdWrEn(mdWrEn),
		.mdHighIn(mdHighIn), .mdLowIn(mdLowIn),
		.muldivResultHigh(muldivResultHigh),
		.muldivResultLow(muldivResultLow), .pcLoad(pcLoad),
		.pcLoadValue(pcLoadValue), .pcAdvance(pcAdvance), .pc(pc));
	irfb_stage_model stg (.clk(clk), .exValid(exValid), .exAddr(exAddr),
		.exData(exData), .memValid(memValid), .memAddr(memAddr),
		.memData(memData), .wbEn(wbEn), .wbSrc(wbSrc), .wbAddr(wbAddr),
		.wbData(wbData), .mdWrEn(mdWrEn), .mdHighIn(mdHighIn),
		.mdLowIn(mdLowIn));

	// ****
	// Helpers
	// ****
	task automatic chk(input string what, input logic [63:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [63:0] val(input int i);
		return {32'hC0DE_0000 + 32'(i), 32'h0000_1000 + 32'(i)};
	endfunction
	task automatic nxt();
		@(posedge clk);
	endtask
	task automatic look();
		@(posedge clk);
		#1;
	endtask

	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		nxt();
		reset <= 1'b1;
		repeat (10) nxt();
		reset <= 1'b0;
		rdAddrA <= 5'h03;
		rdAddrB <= 5'h1f;
		agenOffset <= 64'h0;
		look();
		chk("rdDataA", 64'h0, rdDataA);
		chk("effAddr", 64'h0, effAddr);
		chk("rdDataB", 64'h0, rdDataB);
		chk("high", 64'h0, muldivResultHigh);
		chk("low", 64'h0, muldivResultLow);
		chk("pc", 64'h0, pc);
	endtask
	task automatic t_fill();
		for (int i = 0; i < 32; i++) begin
			nxt();
			stg.wbEn <= 1'b1;
			stg.wbAddr <= 5'(i);
			stg.wbD <= val(i);
			rdAddrA <= 5'(i);
			look();
			chk("thruA", (i == 0) ? 64'h0 : val(i), rdDataA);
		end
		for (int i = 0; i < 32; i++) begin
			nxt();
			stg.wbEn <= 1'b0;
			rdAddrA <= 5'(i);
			rdAddrB <= 5'(31 - i);
			look();
			chk("rdDataA", (i == 0) ? 64'h0 : val(i), rdDataA);
			chk("rdDataB", (i == 31) ? 64'h0 : val(31 - i), rdDataB);
		end
	endtask
	task automatic t_fwd(input logic [4:0] a);
		logic [63:0] cur;
		logic [63:0] e;
		cur = (a == 5'h00) ? 64'h0 : val(a);
		for (int m = 0; m < 8; m++) begin
			nxt();
			{stg.exValid, stg.memValid, stg.wbEn} <= 3'(m);
			{stg.exAddr, stg.memAddr, stg.wbAddr} <= {a, a, a};
			stg.exD <= val(m + 40);
			stg.memD <= val(m + 50);
			stg.wbD <= val(m + 60);
			rdAddrB <= a;
			look();
			e = m[2] ? val(m + 40) : m[1] ? val(m + 50) : m[0] ? val(m + 60) : cur;
			chk("bypassB", (a == 5'h00) ? 64'h0 : e, rdDataB);
			cur = m[0] ? val(m + 60) : cur;
		end
	endtask
	task automatic t_agen();
		nxt();
		{stg.exValid, stg.memValid, stg.wbEn} <= 3'h0;
		rdAddrA <= 5'h05;
		agenOffset <= 64'hFFFF_FFFF_FFFF_FFF0;
		look();
		chk("effAddr", val(5) - 64'h0010, effAddr);
		nxt();
		stg.memValid <= 1'b1;
		stg.memAddr <= 5'h05;
		stg.memD <= 64'h0100;
		look();
		chk("effAddr", 64'h00F0, effAddr);
		chk("rdDataA", 64'h0100, rdDataA);
	endtask
	task automatic t_md();
		nxt();
		stg.memValid <= 1'b0;
		stg.mdWrEn <= 1'b1;
		stg.highD <= 64'h1111_2222_3333_4444;
		stg.lowD <= 64'h5555_6666_7777_8888;
		look();
		chk("high", 64'h1111_2222_3333_4444, muldivResultHigh);
		chk("low", 64'h5555_6666_7777_8888, muldivResultLow);
		nxt();
		stg.mdWrEn <= 1'b0;
		stg.wbEn <= 1'b1;
		stg.wbSrc <= irfb_pkg::WB_MOVE_HIGH;
		stg.wbAddr <= 5'h09;
		nxt();
		stg.wbSrc <= irfb_pkg::WB_MOVE_LOW;
		stg.wbAddr <= 5'h0a;
		nxt();
		stg.mdWrEn <= 1'b1;
		stg.highD <= 64'h0000_0000_0000_0ABC;
		stg.lowD <= 64'h0000_0000_0000_0DEF;
		stg.wbAddr <= 5'h0b;
		nxt();
		stg.mdWrEn <= 1'b0;
		stg.wbSrc <= irfb_pkg::WB_MUL_DIRECT;
		stg.wbAddr <= 5'h0c;
		stg.wbD <= 64'h0000_0000_0012_3456;
		nxt();
		// Read back the last write at once, with no bypass in flight
		stg.wbEn <= 1'b0;
		rdAddrA <= 5'h0c;
		rdAddrB <= 5'h0a;
		look();
		chk("mulDirect", 64'h0012_3456, rdDataA);
		chk("moveLow", 64'h5555_6666_7777_8888, rdDataB);
		nxt();
		rdAddrA <= 5'h0b;
		rdAddrB <= 5'h09;
		look();
		chk("moveLowNew", 64'h0DEF, rdDataA);
		chk("moveHigh", 64'h1111_2222_3333_4444, rdDataB);
		chk("low", 64'h0DEF, muldivResultLow);
		chk("high", 64'h0ABC, muldivResultHigh);
	endtask
	task automatic t_pc();
		nxt();
		pcAdvance <= 1'b1;
		repeat (2) nxt();
		pcAdvance <= 1'b0;
		look();
		chk("pc", 64'h0008, pc);
		nxt();
		pcAdvance <= 1'b1;
		pcLoad <= 1'b1;
		pcLoadValue <= 64'h8000_0000;
		look();
		chk("pcLoad", 64'h8000_0000, pc);
		nxt();
		pcLoad <= 1'b0;
		look();
		chk("pcStep", 64'h8000_0004, pc);
		nxt();
		pcAdvance <= 1'b0;
	endtask

	// ****
	// Run control
	// ****
	task automatic summarize();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Clock at 100 MHz
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			summarize();
		end
	end
	// Main sequence, with a second reset after traffic
	initial begin
		{reset, pcLoad, pcAdvance} = 3'h4;
		{rdAddrA, rdAddrB} = 10'h000;
		{agenOffset, pcLoadValue} = '0;
		{n_errors, comparisons, cyc} = '0;
		t_reset();
		t_fill();
		t_fwd(5'h07);
		t_fwd(5'h00);
		t_agen();
		t_md();
		t_pc();
		t_reset();
		summarize();
	end
endmodule // integer_register_file_bypass_tb_top
